// ### serial_prog_pkg.sv
// constants and types for the serial programming port
// How it works
// - programming is accepted only while the reset pin is held low
// - each eeprom write overwrites its byte, the erase is built in
// - chip erase sets every flash, eeprom and lock byte to 0xFF
// - mosi is sampled on the sck rising edge
// - miso changes on the sck falling edge
// - second enable byte 0x53 is echoed during the third byte
// - page buffer loads bytewise, word picked by seven address bits
// - write page commits the buffer to the page given by word address bits 11..7
// - extended address byte is held until reloaded
// - eeprom written one byte or one four-byte page per instruction, 3.6 ms wait
// - reads return addressed content, flash uses the extended byte
// - releasing reset leaves programming mode
// - poll answer bit 0 is one while a write is pending
// - program memory addresses are word addresses
package serial_prog_pkg;
  // timing
  localparam int CLK_MHZ = 25;
  localparam int FLASH_PAGE_WAIT_US = 4500;
  localparam int EEPROM_BYTE_WAIT_US = 3600;
  localparam int ERASE_WAIT_US = 9000;
  localparam int FLASH_PAGE_WAIT_CYC = FLASH_PAGE_WAIT_US * CLK_MHZ;
  localparam int EEPROM_BYTE_WAIT_CYC = EEPROM_BYTE_WAIT_US * CLK_MHZ;
  localparam int ERASE_WAIT_CYC = ERASE_WAIT_US * CLK_MHZ;
  localparam int TIMER_W = 18;
  // memory geometry
  localparam int FLASH_AW = 12;
  localparam int FLASH_WORDS = 4096;
  localparam int PAGE_AW = 7;
  localparam int PAGE_WORDS = 128;
  localparam int EEPROM_AW = 10;
  localparam int EEPROM_BYTES = 1024;
  localparam int EPAGE_AW = 2;
  localparam int EPAGE_BYTES = 4;
  localparam logic [FLASH_AW-1:0] LAST_PAGE_WORD = 12'h07F;
  localparam logic [FLASH_AW-1:0] LAST_EPAGE_BYTE = 12'h003;
  localparam logic [FLASH_AW-1:0] LAST_FLASH_WORD = 12'hFFF;
  // values
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] FUSE_RESET = 8'hFF;
  localparam logic [15:0] ENABLE_WORD = 16'hAC53;
  localparam logic [31:0] SIGNATURE = 32'h00A1B2C3; // arbitrary value
  localparam logic [7:0] CAL_BYTE = 8'h5A; // arbitrary value
  // first instruction byte
  localparam logic [7:0] CMD_AC = 8'hAC;
  localparam logic [7:0] CMD_POLL = 8'hF0;
  localparam logic [7:0] CMD_LD_EXT = 8'h4D;
  localparam logic [7:0] CMD_LD_HI = 8'h48;
  localparam logic [7:0] CMD_LD_LO = 8'h40;
  localparam logic [7:0] CMD_LD_EE = 8'hC1;
  localparam logic [7:0] CMD_RD_HI = 8'h28;
  localparam logic [7:0] CMD_RD_LO = 8'h20;
  localparam logic [7:0] CMD_RD_EE = 8'hA0;
  localparam logic [7:0] CMD_RD_LOCK = 8'h58;
  localparam logic [7:0] CMD_RD_SIG = 8'h30;
  localparam logic [7:0] CMD_RD_FUSE = 8'h50;
  localparam logic [7:0] CMD_RD_CAL = 8'h38;
  localparam logic [7:0] CMD_WR_PAGE = 8'h4C;
  localparam logic [7:0] CMD_WR_EE = 8'hC0;
  localparam logic [7:0] CMD_WR_EPAGE = 8'hC2;
  // second byte after CMD_AC
  localparam logic [7:0] SUB_ERASE = 8'h80;
  localparam logic [7:0] SUB_LOCK = 8'hE0;
  localparam logic [7:0] SUB_FUSE = 8'hA0;
  localparam logic [7:0] SUB_FUSE_HI = 8'hA8;
  localparam logic [7:0] SUB_FUSE_EXT = 8'hA4;
  typedef enum logic [1:0] {EX_IDLE = 2'h0, EX_BUSY = 2'h1} exec_state_t;
  typedef enum logic [2:0] {
    OP_NONE, OP_BYTE, OP_FLASH, OP_EEPROM, OP_ERASE
  } sweep_op_t;
endpackage

// ### cmd_fifo.sv
// parameterised fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module cmd_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg, rd_ptr_reg;
  logic [AW:0] count_reg;
  logic do_wr, do_rd;

  // depth must be a power of two so the pointers wrap by themselves
  assign in_ready_o = count_reg != (AW+1)'(DEPTH);
  assign out_valid_o = count_reg != '0;
  assign out_data_o = mem[rd_ptr_reg];
  assign do_wr = in_valid_i & in_ready_o;
  assign do_rd = out_valid_o & out_ready_i;

  // storage
  always_ff @(posedge clk_i) begin
    if (do_wr) begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (do_wr) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (do_rd) rd_ptr_reg <= rd_ptr_reg + 1'b1;
      count_reg <= count_reg + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end

  fill_bound_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      count_reg <= (AW+1)'(DEPTH)) else $error("fifo level above depth");
endmodule // cmd_fifo
`default_nettype wire

// ### serial_prog_port.sv
// serial programming port: link front end, command executor, memories
`timescale 1ns/1ps
`default_nettype none
module serial_prog_port #(
  parameter int FLASH_WAIT = serial_prog_pkg::FLASH_PAGE_WAIT_CYC,
  parameter int EEPROM_WAIT = serial_prog_pkg::EEPROM_BYTE_WAIT_CYC,
  parameter int ERASE_WAIT = serial_prog_pkg::ERASE_WAIT_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic reset_n_pin_i,
  input wire logic sck_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_o,
  output logic prog_mode_o,
  output logic write_pending_flag_o,
  output logic overrun_o,
  output logic run_enable_o
);
  import serial_prog_pkg::*;

  logic [1:0] sck_sync_reg, mosi_sync_reg, rstn_sync_reg;
  logic sck_prev_reg;
  logic link_on, sck_rise, sck_fall;

  // two-flop synchronisers; the third sck stage only feeds edge finding
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sck_sync_reg <= 2'h0;
      mosi_sync_reg <= 2'h0;
      rstn_sync_reg <= 2'h0;
      sck_prev_reg <= 1'b0;
    end else begin
      sck_sync_reg <= {sck_sync_reg[0], sck_i};
      mosi_sync_reg <= {mosi_sync_reg[0], mosi_i};
      rstn_sync_reg <= {rstn_sync_reg[0], reset_n_pin_i};
      sck_prev_reg <= sck_sync_reg[1];
    end
  end

  // link is live only while the device reset pin is low
  assign link_on = ~rstn_sync_reg[1];
  assign sck_rise = link_on & sck_sync_reg[1] & ~sck_prev_reg;
  assign sck_fall = link_on & ~sck_sync_reg[1] & sck_prev_reg;

  logic [4:0] bit_cnt_reg;
  logic [7:0] rx_shift_reg, rx_next;
  logic [23:0] head_reg;
  logic [31:0] word_in;
  logic [1:0] byte_idx;
  logic enabled_reg, byte_done;

  assign rx_next = {rx_shift_reg[6:0], mosi_sync_reg[1]};
  assign byte_done = sck_rise & (bit_cnt_reg[2:0] == 3'h7);
  assign byte_idx = bit_cnt_reg[4:3];
  assign word_in = {head_reg, rx_next};

  // framing; a reset pin pulse clears it, which is how a lost sync recovers
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bit_cnt_reg <= 5'h00;
      rx_shift_reg <= 8'h00;
      head_reg <= 24'h000000;
      enabled_reg <= 1'b0;
    end else if (!link_on) begin
      bit_cnt_reg <= 5'h00;
      rx_shift_reg <= 8'h00;
      head_reg <= 24'h000000;
      enabled_reg <= 1'b0;
    end else if (sck_rise) begin
      bit_cnt_reg <= bit_cnt_reg + 5'h01; // wraps after 32 edges
      rx_shift_reg <= rx_next;
      if (byte_done) head_reg <= {head_reg[15:0], rx_next};
      if (byte_done && byte_idx == 2'h3 && word_in[31:16] == ENABLE_WORD) begin
        enabled_reg <= 1'b1;
      end
    end
  end

  // memories
  logic [7:0] flash_lo_mem [FLASH_WORDS];
  logic [7:0] flash_hi_mem [FLASH_WORDS];
  logic [7:0] page_lo_mem [PAGE_WORDS];
  logic [7:0] page_hi_mem [PAGE_WORDS];
  logic [7:0] eeprom_mem [EEPROM_BYTES];
  logic [7:0] ebuf_mem [EPAGE_BYTES];
  logic [EPAGE_BYTES-1:0] ebuf_vld_reg;
  logic [7:0] fuse_lo_reg, fuse_hi_reg, fuse_ext_reg, lock_reg;
  logic [7:0] ext_addr_reg;

  // only the low word addresses are backed; the rest read as erased
  function automatic logic flash_hit(input logic [7:0] ext, input logic [7:0] msb);
    return {ext, msb[7:FLASH_AW-8]} == 12'h000;
  endfunction

  // commands that change state; reads and polls never queue
  function automatic logic is_exec(input logic [7:0] op);
    return op inside {CMD_LD_EXT, CMD_LD_LO, CMD_LD_HI, CMD_LD_EE,
                      CMD_WR_PAGE, CMD_WR_EE, CMD_WR_EPAGE, CMD_AC};
  endfunction

  logic busy_any;
  logic [7:0] rd_byte;
  logic [FLASH_AW-1:0] rd_waddr;
  logic [EEPROM_AW-1:0] rd_eaddr;
  assign rd_waddr = {head_reg[FLASH_AW-9:0], rx_next}; // word address
  assign rd_eaddr = {head_reg[1:0], rx_next};

  // answer byte, chosen once bytes 1 to 3 are in
  always_comb begin
    rd_byte = rx_next;
    case (head_reg[15:8])
      CMD_POLL: rd_byte = {7'h00, busy_any};
      CMD_RD_LO: rd_byte = flash_hit(ext_addr_reg, head_reg[7:0]) ?
                           flash_lo_mem[rd_waddr] : ERASED_BYTE;
      CMD_RD_HI: rd_byte = flash_hit(ext_addr_reg, head_reg[7:0]) ?
                           flash_hi_mem[rd_waddr] : ERASED_BYTE;
      CMD_RD_EE: rd_byte = eeprom_mem[rd_eaddr];
      CMD_RD_SIG: rd_byte = SIGNATURE[{rx_next[1:0], 3'h0} +: 8];
      CMD_RD_CAL: rd_byte = CAL_BYTE;
      CMD_RD_FUSE: rd_byte = head_reg[3] ? fuse_ext_reg : fuse_lo_reg;
      CMD_RD_LOCK: rd_byte = head_reg[3] ? fuse_hi_reg : lock_reg;
      default: rd_byte = rx_next;
    endcase
  end

  logic [7:0] tx_shift_reg;
  logic miso_reg, miso_oe_reg;

  // output shifter: loaded at a byte end, shifted on falling sck
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_shift_reg <= 8'h00;
      miso_reg <= 1'b0;
      miso_oe_reg <= 1'b0;
    end else if (!link_on) begin
      tx_shift_reg <= 8'h00;
      miso_reg <= 1'b0;
      miso_oe_reg <= 1'b0;
    end else begin
      miso_oe_reg <= 1'b1;
      if (byte_done) begin
        tx_shift_reg <= (byte_idx == 2'h2) ? rd_byte : rx_next;
      end else if (sck_fall) begin
        miso_reg <= tx_shift_reg[7];
        tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
      end
    end
  end

  logic push, fifo_in_ready, fifo_out_valid, pop, overrun_reg;
  logic [31:0] ex_word;
  assign push = byte_done & (byte_idx == 2'h3) & enabled_reg &
                is_exec(head_reg[23:16]);

  // a full queue drops the word; the sticky flag tells the programmer
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      overrun_reg <= 1'b0;
    end else if (push && !fifo_in_ready) begin
      overrun_reg <= 1'b1;
    end else if (!link_on) begin
      overrun_reg <= 1'b0;
    end
  end

  cmd_fifo #(.WIDTH(32), .DEPTH(16)) cmd_q (
    .clk_i(ref_clk_i),
    .rst_i(rst_i),
    .in_valid_i(push),
    .in_data_i(word_in),
    .in_ready_o(fifo_in_ready),
    .out_valid_o(fifo_out_valid),
    .out_data_o(ex_word),
    .out_ready_i(pop)
  );

  exec_state_t ex_state_reg;
  sweep_op_t op_reg, start_op;
  logic [TIMER_W-1:0] timer_reg, start_wait;
  logic [FLASH_AW-1:0] sweep_reg, sweep_last_reg, start_last;
  logic [7:0] ex_op, ex_b2, ex_b3, ex_b4;
  logic sweep_end, busy;
  assign {ex_op, ex_b2, ex_b3, ex_b4} = ex_word;
  assign pop = fifo_out_valid & (ex_state_reg == EX_IDLE);
  assign sweep_end = sweep_reg == sweep_last_reg;
  assign busy = ex_state_reg == EX_BUSY;
  assign busy_any = busy | fifo_out_valid;

  // which self-timed operation a popped word starts
  always_comb begin
    start_op = OP_NONE;
    start_wait = '0;
    start_last = '0;
    if (pop) begin
      case (ex_op)
        CMD_WR_PAGE: if (flash_hit(ext_addr_reg, ex_b2)) begin
          start_op = OP_FLASH;
          start_wait = TIMER_W'(FLASH_WAIT);
          start_last = LAST_PAGE_WORD;
        end
        CMD_WR_EE: begin
          start_op = OP_BYTE;
          start_wait = TIMER_W'(EEPROM_WAIT);
        end
        CMD_WR_EPAGE: begin
          start_op = OP_EEPROM;
          start_wait = TIMER_W'(EEPROM_WAIT);
          start_last = LAST_EPAGE_BYTE;
        end
        CMD_AC: if (ex_b2 == SUB_ERASE) begin
          start_op = OP_ERASE;
          start_wait = TIMER_W'(ERASE_WAIT);
          start_last = LAST_FLASH_WORD;
        end else if (ex_b2 inside {SUB_LOCK, SUB_FUSE, SUB_FUSE_HI, SUB_FUSE_EXT}) begin
          start_op = OP_BYTE;
          start_wait = TIMER_W'(EEPROM_WAIT);
        end
        default: start_op = OP_NONE;
      endcase
    end
  end

  // executor: busy until both the wait time and the sweep are over
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ex_state_reg <= EX_IDLE;
      op_reg <= OP_NONE;
      timer_reg <= '0;
      sweep_reg <= '0;
      sweep_last_reg <= '0;
    end else begin
      case (ex_state_reg)
        EX_IDLE: if (start_op != OP_NONE) begin
          ex_state_reg <= EX_BUSY;
          op_reg <= start_op;
          timer_reg <= start_wait;
          sweep_reg <= '0;
          sweep_last_reg <= start_last;
        end
        EX_BUSY: begin
          if (timer_reg != '0) timer_reg <= timer_reg - 1'b1;
          if (!sweep_end) sweep_reg <= sweep_reg + 1'b1;
          if (timer_reg == '0 && sweep_end) begin
            ex_state_reg <= EX_IDLE;
            op_reg <= OP_NONE;
          end
        end
        default: ex_state_reg <= EX_IDLE;
      endcase
    end
  end

  logic [FLASH_AW-PAGE_AW-1:0] page_reg;
  logic [EEPROM_AW-EPAGE_AW-1:0] epage_reg;

  // address latches; the extended byte survives until reloaded
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ext_addr_reg <= 8'h00;
      page_reg <= '0;
      epage_reg <= '0;
    end else if (pop) begin
      if (ex_op == CMD_LD_EXT) ext_addr_reg <= ex_b3;
      if (start_op == OP_FLASH) page_reg <= {ex_b2[FLASH_AW-9:0], ex_b3[7]};
      if (ex_op == CMD_WR_EPAGE) epage_reg <= {ex_b2[1:0], ex_b3[7:2]};
    end
  end

  // page buffer fill, seven address bits pick the word
  always_ff @(posedge ref_clk_i) begin
    if (pop && ex_op == CMD_LD_LO) page_lo_mem[ex_b3[PAGE_AW-1:0]] <= ex_b4;
    if (pop && ex_op == CMD_LD_HI) page_hi_mem[ex_b3[PAGE_AW-1:0]] <= ex_b4;
  end

  logic [PAGE_WORDS-1:0] lo_vld_reg, hi_vld_reg;
  // words never loaded commit as erased, so a partial page leaves no junk
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lo_vld_reg <= '0;
      hi_vld_reg <= '0;
    end else if (pop && ex_op == CMD_LD_LO) begin
      lo_vld_reg[ex_b3[PAGE_AW-1:0]] <= 1'b1;
    end else if (pop && ex_op == CMD_LD_HI) begin
      hi_vld_reg[ex_b3[PAGE_AW-1:0]] <= 1'b1;
    end else if (busy && op_reg == OP_FLASH && timer_reg == '0 && sweep_end) begin
      lo_vld_reg <= '0; // emptied on the last commit cycle
      hi_vld_reg <= '0;
    end
  end

  // flash array: one word per cycle during a page commit or erase
  always_ff @(posedge ref_clk_i) begin
    if (busy && op_reg == OP_FLASH) begin
      flash_lo_mem[{page_reg, sweep_reg[PAGE_AW-1:0]}] <=
        lo_vld_reg[sweep_reg[PAGE_AW-1:0]] ?
        page_lo_mem[sweep_reg[PAGE_AW-1:0]] : ERASED_BYTE;
      flash_hi_mem[{page_reg, sweep_reg[PAGE_AW-1:0]}] <=
        hi_vld_reg[sweep_reg[PAGE_AW-1:0]] ?
        page_hi_mem[sweep_reg[PAGE_AW-1:0]] : ERASED_BYTE;
    end else if (busy && op_reg == OP_ERASE) begin
      flash_lo_mem[sweep_reg] <= ERASED_BYTE;
      flash_hi_mem[sweep_reg] <= ERASED_BYTE;
    end
  end

  // eeprom: a byte write replaces the old value, no erase needed first
  always_ff @(posedge ref_clk_i) begin
    if (pop && ex_op == CMD_WR_EE) begin
      eeprom_mem[{ex_b2[1:0], ex_b3}] <= ex_b4;
    end else if (busy && op_reg == OP_EEPROM && ebuf_vld_reg[sweep_reg[1:0]]) begin
      eeprom_mem[{epage_reg, sweep_reg[1:0]}] <= ebuf_mem[sweep_reg[1:0]];
    end else if (busy && op_reg == OP_ERASE) begin
      eeprom_mem[sweep_reg[EEPROM_AW-1:0]] <= ERASED_BYTE;
    end
    if (pop && ex_op == CMD_LD_EE) ebuf_mem[ex_b3[1:0]] <= ex_b4;
  end

  // eeprom page buffer: only loaded bytes are written back
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ebuf_vld_reg <= '0;
    end else if (pop && ex_op == CMD_LD_EE) begin
      ebuf_vld_reg[ex_b3[1:0]] <= 1'b1;
    end else if (busy && op_reg == OP_EEPROM && sweep_end) begin
      ebuf_vld_reg <= '0;
    end
  end

  // fuse and lock bytes; erase or a lock write of 0xFF clears the lock
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fuse_lo_reg <= FUSE_RESET;
      fuse_hi_reg <= FUSE_RESET;
      fuse_ext_reg <= FUSE_RESET;
      lock_reg <= FUSE_RESET;
    end else if (pop && ex_op == CMD_AC) begin
      if (ex_b2 == SUB_FUSE) fuse_lo_reg <= ex_b4;
      if (ex_b2 == SUB_FUSE_HI) fuse_hi_reg <= ex_b4;
      if (ex_b2 == SUB_FUSE_EXT) fuse_ext_reg <= ex_b4;
      if (ex_b2 == SUB_LOCK) lock_reg <= ex_b4;
    end else if (busy && op_reg == OP_ERASE) begin
      lock_reg <= ERASED_BYTE;
    end
  end

  logic pending_reg;
  // pending covers queued words as well as the running operation
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pending_reg <= 1'b0;
    end else begin
      pending_reg <= busy_any;
    end
  end

  assign miso_o = miso_reg;
  assign miso_oe_o = miso_oe_reg;
  assign prog_mode_o = enabled_reg;
  assign write_pending_flag_o = pending_reg;
  assign overrun_o = overrun_reg;
  assign run_enable_o = rstn_sync_reg[1];

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence erase_pop_s;
    pop && ex_op == CMD_AC && ex_b2 == SUB_ERASE;
  endsequence
  sequence busy_run_s;
    busy[*8];
  endsequence

  sample_rise_a:
    assert property (sck_rise |=> rx_shift_reg[0] == $past(mosi_sync_reg[1]))
      else $error("mosi not taken on rising sck");
  miso_fall_a:
    assert property ($changed(miso_reg) && link_on && $past(link_on) |-> $past(sck_fall))
      else $error("miso moved away from falling sck");
  echo_byte_a:
    assert property (byte_done && byte_idx == 2'h1 && rx_next == ENABLE_WORD[7:0]
      |=> tx_shift_reg == ENABLE_WORD[7:0]) else $error("enable echo not loaded");
  enable_gate_a:
    assert property (!enabled_reg && !busy_any |=> !busy_any)
      else $error("queued before enable");
  count_wrap_a:
    assert property (byte_done && byte_idx == 2'h3 |=> bit_cnt_reg == 5'h00)
      else $error("instruction not 32 edges");
  exit_mode_a:
    assert property (!link_on |=> !enabled_reg && !miso_oe_reg && bit_cnt_reg == 5'h00)
      else $error("mode kept after reset release");
  erase_busy_a:
    assert property (erase_pop_s |=> busy_run_s) else $error("erase ended too soon");
  pending_bit_a:
    assert property (busy |=> write_pending_flag_o) else $error("pending bit low while busy");
  ext_hold_a:
    assert property ($changed(ext_addr_reg) |-> $past(pop && ex_op == CMD_LD_EXT))
      else $error("extended address changed by itself");
  page_load_a:
    assert property (pop && ex_op == CMD_LD_LO |=>
      page_lo_mem[$past(ex_b3[PAGE_AW-1:0])] == $past(ex_b4)) else $error("page byte lost");
endmodule // serial_prog_port
`default_nettype wire

// ### prog_model.sv
// external programmer model driving the serial programming link
`timescale 1ns/1ps
`default_nettype none
module prog_model (
  input wire logic clk_i,
  input wire logic miso_i,
  output logic reset_n_pin_o,
  output logic sck_o,
  output logic mosi_o
);
  // power-up with reset pin high and sck low, then reset low
  initial begin
    reset_n_pin_o = 1'b1;
    sck_o = 1'b0;
    mosi_o = 1'b0;
  end

  // reset pin level, then settle time for the device's synchronisers
  task automatic pin(input logic v);
    reset_n_pin_o <= v;
    repeat (10) @(posedge clk_i);
  endtask

  // one whole instruction, msb first, 32 rising edges
  // four-cycle phases keep each phase above the cpu-clock floor
  // miso is taken just before each rise, long after the fall that moved it
  task automatic xfer(input logic [31:0] cmd, output logic [31:0] resp);
    for (int i = 31; i >= 0; i--) begin
      mosi_o <= cmd[i];
      repeat (4) @(posedge clk_i);
      resp[i] = miso_i; // bit moved on the previous fall
      sck_o <= 1'b1; // device takes mosi on this edge
      repeat (4) @(posedge clk_i);
      sck_o <= 1'b0;
    end
    // data line left at the inverse of its last bit between instructions
    mosi_o <= ~cmd[0];
    repeat (4) @(posedge clk_i);
  endtask
endmodule // prog_model
`default_nettype wire

// ### test_serial_memory_programming.sv
// self-checking bench for the serial programming port
`timescale 1ns/1ps
`default_nettype none
module test_serial_memory_programming;
  import serial_prog_pkg::*;
  logic ref_clk_i;
  logic rst_i;
  logic reset_n_pin;
  logic sck;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic prog_mode;
  logic pending;
  logic overrun;
  logic run_enable;
  int errors;
  int total_checks;
  int cycles = 0;
  logic [31:0] r;

  // short waits keep the run small; queue overflow needs slow eeprom writes
  serial_prog_port #(.FLASH_WAIT(200), .EEPROM_WAIT(1000), .ERASE_WAIT(5000)) DUT (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .reset_n_pin_i(reset_n_pin), .sck_i(sck),
    .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe), .prog_mode_o(prog_mode),
    .write_pending_flag_o(pending), .overrun_o(overrun), .run_enable_o(run_enable)
  );
  prog_model prog (.clk_i(ref_clk_i), .miso_i(miso), .reset_n_pin_o(reset_n_pin),
    .sck_o(sck), .mosi_o(mosi));

  // 25 MHz clock
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // bounded busy poll; flash access waits here, never by guesswork
  task automatic wait_idle();
    for (int n = 0; n < 250; n++) begin
      prog.xfer(32'hF000_0000, r);
      if (r[0] === 1'b0) break;
    end
    chk_byte(r[7:0], 8'h00);
  endtask

  task automatic t_before_enable();
    prog.pin(1'b0);
    chk_flag(miso_oe, 1'b1);
    chk_flag(run_enable, 1'b0);
    prog.xfer(32'hAC80_0000, r);
    repeat (4) @(posedge ref_clk_i);
    chk_flag(pending, 1'b0);
    chk_flag(prog_mode, 1'b0);
  endtask

  task automatic t_enable();
    prog.xfer(32'hAC53_0000, r);
    chk_byte(r[23:16], 8'hAC);
    chk_byte(r[15:8], 8'h53);
    chk_byte(r[7:0], 8'h00);
    repeat (5) @(posedge ref_clk_i);
    chk_flag(prog_mode, 1'b1);
  endtask

  task automatic t_erase();
    prog.xfer(32'hAC80_0000, r);
    chk_flag(pending, 1'b1);
    prog.xfer(32'hF000_0000, r);
    chk_byte(r[7:0], 8'h01);
    wait_idle();
    prog.xfer(32'h2000_8500, r);
    chk_byte(r[7:0], ERASED_BYTE);
    prog.xfer(32'hA001_2300, r);
    chk_byte(r[7:0], ERASED_BYTE);
  endtask

  // word 0x85 is word 5 of page 1; page write names another word of it
  task automatic t_flash();
    prog.xfer(32'h4D00_0000, r);
    prog.xfer(32'h4000_853C, r);
    prog.xfer(32'h4800_85C3, r);
    prog.xfer(32'h4000_8611, r);
    prog.xfer(32'h4C00_8000, r);
    chk_flag(pending, 1'b1);
    wait_idle();
    prog.xfer(32'h2000_8500, r);
    chk_byte(r[7:0], 8'h3C);
    prog.xfer(32'h2800_8500, r);
    chk_byte(r[7:0], 8'hC3);
    prog.xfer(32'h2000_8600, r);
    chk_byte(r[7:0], 8'h11);
    prog.xfer(32'h2800_8600, r);
    chk_byte(r[7:0], ERASED_BYTE);
  endtask

  // second write over a written byte, with no erase between
  task automatic t_eeprom();
    prog.xfer(32'hC001_235A, r);
    wait_idle();
    prog.xfer(32'hA001_2300, r);
    chk_byte(r[7:0], 8'h5A);
    prog.xfer(32'hC001_23A5, r);
    wait_idle();
    prog.xfer(32'hA001_2300, r);
    chk_byte(r[7:0], 8'hA5);
  endtask

  // eeprom page of two loaded bytes, then a fuse byte and the fixed bytes
  task automatic t_extras();
    prog.xfer(32'hC100_0177, r);
    prog.xfer(32'hC100_0388, r);
    prog.xfer(32'hC201_0000, r);
    wait_idle();
    prog.xfer(32'hA001_0100, r);
    chk_byte(r[7:0], 8'h77);
    prog.xfer(32'hA001_0000, r);
    chk_byte(r[7:0], ERASED_BYTE);
    prog.xfer(32'hACA0_00E2, r);
    wait_idle();
    prog.xfer(32'h5000_0000, r);
    chk_byte(r[7:0], 8'hE2);
    prog.xfer(32'h5808_0000, r);
    chk_byte(r[7:0], FUSE_RESET);
    prog.xfer(32'h3000_0100, r);
    chk_byte(r[7:0], SIGNATURE[15:8]);
    prog.xfer(32'h3800_0000, r);
    chk_byte(r[7:0], CAL_BYTE);
  endtask

  // writes arrive faster than they finish until the queue refuses
  task automatic t_overrun();
    for (int k = 0; k < 28; k++) begin
      prog.xfer({16'hC000, k[7:0], k[7:0]}, r);
    end
    chk_flag(overrun, 1'b1);
    chk_flag(pending, 1'b1);
    wait_idle();
    prog.xfer(32'hA000_0300, r);
    chk_byte(r[7:0], 8'h03);
  endtask

  task automatic t_leave();
    prog.pin(1'b1);
    chk_flag(prog_mode, 1'b0);
    chk_flag(run_enable, 1'b1);
    chk_flag(miso_oe, 1'b0);
    chk_flag(overrun, 1'b0);
  endtask

  // hang guard, well above the expected run of about 43000 cycles
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      errors++;
      close_out();
    end
  end

  // reset, then the scenarios in order
  initial begin
    rst_i = 1'b1;
    errors = 0;
    total_checks = 0;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    repeat (5) @(posedge ref_clk_i);
    chk_flag(run_enable, 1'b1);
    t_before_enable();
    t_enable();
    t_erase();
    t_flash();
    t_eeprom();
    t_extras();
    t_overrun();
    t_leave();
    close_out();
  end
endmodule // test_serial_memory_programming
`default_nettype wire
